//--- inc/cphu_consts.vh
// Constants for the cache prefetch hint unit.
`ifndef CPHU_CONSTS_VH
`define CPHU_CONSTS_VH
`define CPHU_OPC_HI        31
`define CPHU_OPC_LO        26
`define CPHU_BASE_HI       25
`define CPHU_BASE_LO       21
`define CPHU_HINT_HI       20
`define CPHU_HINT_LO       16
`define CPHU_DISP_HI       15
`define CPHU_DISP_SIGN     15
`define CPHU_OPC_FETCH     6'h33
`define CPHU_HINT_LOAD     5'h00
`define CPHU_HINT_STORE    5'h01
`define CPHU_HINT_LD_STRM  5'h04
`define CPHU_HINT_ST_STRM  5'h05
`define CPHU_HINT_LD_RETN  5'h06
`define CPHU_HINT_ST_RETN  5'h07
`define CPHU_HINT_WB_INV   5'h19
`define CPHU_HINT_ZERO     5'h1e
`define CPHU_ACT_NONE      3'h0
`define CPHU_ACT_FILL      3'h1
`define CPHU_ACT_WB_INV    3'h2
`define CPHU_ACT_ZERO      3'h3
`define CPHU_PLACE_NORMAL  2'h0
`define CPHU_PLACE_STREAM  2'h1
`define CPHU_PLACE_RETAIN  2'h2
`define CPHU_REPORT_ERR    1'b0
`endif

//--- rtl/cphu_decode.v
// Instruction field decode and hint classification for the prefetch unit.
`include "cphu_consts.vh"
module cphu_decode (
  input  wire [31:0] instr_in,       // Instruction word from issue.
  output wire        is_fetch_out,   // Word is a prefetch instruction.
  output wire [4:0]  base_sel_out,   // Base register number.
  output wire [4:0]  hint_out,       // Usage hint.
  output wire [31:0] disp_ext_out,   // Sign-extended displacement.
  output reg  [2:0]  action_out,     // Cache action class.
  output reg         for_store_out,  // Fetch with write intent.
  output reg  [1:0]  place_out       // Placement class.
);
  // Fixed field positions of the prefetch format.
  assign is_fetch_out = (instr_in[`CPHU_OPC_HI:`CPHU_OPC_LO] == `CPHU_OPC_FETCH);
  assign base_sel_out = instr_in[`CPHU_BASE_HI:`CPHU_BASE_LO];
  assign hint_out     = instr_in[`CPHU_HINT_HI:`CPHU_HINT_LO];
  // The displacement is signed, so its top bit is copied upward.
  assign disp_ext_out = {{16{instr_in[`CPHU_DISP_SIGN]}}, instr_in[`CPHU_DISP_HI:0]};

  // Map the hint onto an action; unlisted hints do nothing at all.
  always @* begin
    action_out    = `CPHU_ACT_NONE;
    for_store_out = 1'b0;
    place_out     = `CPHU_PLACE_NORMAL;
    case (hint_out)
      `CPHU_HINT_LOAD: begin
        action_out = `CPHU_ACT_FILL;
      end
      `CPHU_HINT_STORE: begin
        action_out    = `CPHU_ACT_FILL;
        for_store_out = 1'b1;
      end
      `CPHU_HINT_LD_STRM, `CPHU_HINT_ST_STRM: begin
        action_out    = `CPHU_ACT_FILL;
        for_store_out = hint_out[0];
        place_out     = `CPHU_PLACE_STREAM;
      end
      `CPHU_HINT_LD_RETN, `CPHU_HINT_ST_RETN: begin
        action_out    = `CPHU_ACT_FILL;
        for_store_out = hint_out[0];
        place_out     = `CPHU_PLACE_RETAIN;
      end
      `CPHU_HINT_WB_INV: begin
        action_out = `CPHU_ACT_WB_INV;
      end
      `CPHU_HINT_ZERO: begin
        action_out = `CPHU_ACT_ZERO;
      end
      default: begin
        // Reserved and free hints are treated as no action.
        action_out = `CPHU_ACT_NONE;
      end
    endcase
  end
endmodule // cphu_decode

//--- rtl/cphu_addr_gen.v
// Effective address adder for the prefetch unit.
module cphu_addr_gen (
  input  wire [31:0] base_in,   // Base register contents.
  input  wire [31:0] disp_in,   // Sign-extended displacement.
  output wire [31:0] ea_out     // Effective byte address.
);
  // Wraparound is intended; the carry out is simply discarded.
  wire [32:0] sum;              // Full-width sum.
  assign sum    = {1'b0, base_in} + {1'b0, disp_in};
  assign ea_out = sum[31:0];
endmodule // cphu_addr_gen

//--- rtl/cphu_unit.v
// Prefetch hint execution unit: decodes, translates and issues cache actions.
`include "cphu_consts.vh"
// Summary of operation
// - Decode opcode, base, hint, displacement fields.
// - Address is base plus sign-extended displacement.
// - Only zero-line allocation changes visible state.
// - Address faults suppressed, no data moved.
// - Invisible actions like writeback still allowed.
// - Side-effect error reporting fixed per design.
// - Never access uncached addresses.
// - Use address's own memory access type.
// - Cached location fetches a containing block.
// - Hint 0 loads, hint 1 stores.
// - Hints 4, 5 place as streamed.
// - Hints 6, 7 place as retained.
// - Reserved hints get no action.
// - Hint 25 writes back then invalidates.
// - Hints 26-29, 31 treated as none.
// - Hint 30 on hit does nothing.
// - Hint 30 miss: evict, zero, valid dirty.
// - No translation: no fetch, no exception.
// - Locked lines are left untouched.
module cphu_unit (
  input  wire        ref_clk_in,        // Core clock.
  input  wire        reset_n_in,        // Asynchronous reset, active low.
  input  wire        issue_valid_in,    // Issue offers an instruction.
  input  wire [31:0] issue_instr_in,    // Instruction word.
  input  wire [31:0] issue_base_in,     // Contents of the base register.
  output wire [4:0]  issue_base_sel_out, // Base register number to read.
  output wire        issue_ready_out,   // Unit can accept a prefetch.
  output reg         retire_out,        // Prefetch retired, one-cycle pulse.
  output reg         error_out,         // Side-effect error reported, pulse.
  output reg         xlat_req_out,      // Translation request pulse.
  output reg  [31:0] xlat_vaddr_out,    // Virtual address to translate.
  input  wire        xlat_done_in,      // Translation answer valid.
  input  wire        xlat_hit_in,       // Translation present.
  input  wire        xlat_fault_in,     // Address would raise an exception.
  input  wire        xlat_cached_in,    // Memory access type is cached.
  input  wire [2:0]  xlat_mat_in,       // Memory access type code.
  input  wire [31:0] xlat_paddr_in,     // Physical address.
  output reg         tag_req_out,       // Cache lookup request pulse.
  output reg  [31:0] tag_addr_out,      // Lookup physical address.
  input  wire        tag_done_in,       // Lookup answer valid.
  input  wire        tag_hit_in,        // Line present.
  input  wire        tag_dirty_in,      // Hit line is dirty.
  input  wire        tag_locked_in,     // Hit line or victim is locked.
  input  wire        cache_ready_in,    // Cache accepts a command.
  output reg         cache_cmd_valid_out, // Cache command valid.
  output reg  [2:0]  cache_cmd_out,     // Cache action class.
  output reg  [31:0] cache_addr_out,    // Command physical address.
  output reg  [2:0]  cache_mat_out,     // Access type for the command.
  output reg         cache_for_store_out, // Fill with write intent.
  output reg  [1:0]  cache_place_out,   // Placement class.
  input  wire        cache_err_in       // Bus or cache error from action.
);
  // Controller states.
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for a prefetch.
  localparam [2:0] ST_XREQ = 3'h1; // Ask for translation.
  localparam [2:0] ST_XWT  = 3'h2; // Wait for translation.
  localparam [2:0] ST_TREQ = 3'h3; // Ask for a tag lookup.
  localparam [2:0] ST_TWT  = 3'h4; // Wait for the lookup.
  localparam [2:0] ST_CMD  = 3'h5; // Hand command to the cache.

  reg  [2:0]  state;        // Current state.
  reg  [2:0]  next_state;   // Next state.
  reg  [2:0]  act;          // Latched action class.
  reg         for_store;    // Latched write intent.
  reg  [1:0]  place;        // Latched placement.
  reg  [31:0] paddr;        // Latched physical address.
  reg  [2:0]  mat;          // Latched access type.
  wire        dec_fetch;    // Decoded as prefetch.
  wire [4:0]  dec_hint;     // Decoded hint.
  wire [31:0] dec_disp;     // Extended displacement.
  wire [2:0]  dec_act;      // Decoded action.
  wire        dec_store;    // Decoded write intent.
  wire [1:0]  dec_place;    // Decoded placement.
  wire [31:0] ea;           // Effective address.
  wire        accept;       // Prefetch taken this cycle.

  cphu_decode u_decode (
    .instr_in      (issue_instr_in),
    .is_fetch_out  (dec_fetch),
    .base_sel_out  (issue_base_sel_out),
    .hint_out      (dec_hint),
    .disp_ext_out  (dec_disp),
    .action_out    (dec_act),
    .for_store_out (dec_store),
    .place_out     (dec_place)
  );

  cphu_addr_gen u_addr (
    .base_in (issue_base_in),
    .disp_in (dec_disp),
    .ea_out  (ea)
  );

  // Accept only when idle, so issue waits while an earlier prefetch is still in translation, lookup or command handoff.
  assign issue_ready_out = (state == ST_IDLE);
  assign accept          = issue_valid_in && dec_fetch && issue_ready_out;

  // State transitions; every abort path simply drops back to idle silently.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          // No-action hints retire without touching anything.
          next_state = (dec_act == `CPHU_ACT_NONE) ? ST_IDLE : ST_XREQ;
        end
      end
      ST_XREQ: begin
        next_state = ST_XWT;
      end
      ST_XWT: begin
        if (xlat_done_in) begin
          if (xlat_fault_in || !xlat_hit_in) begin
            next_state = ST_IDLE;
          end else if (!xlat_cached_in) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_TREQ;
          end
        end
      end
      ST_TREQ: begin
        next_state = ST_TWT;
      end
      ST_TWT: begin
        if (tag_done_in) begin
          if (tag_locked_in) begin
            next_state = ST_IDLE;
          end else if (act == `CPHU_ACT_ZERO && tag_hit_in) begin
            next_state = ST_IDLE;
          end else if (act == `CPHU_ACT_WB_INV && !tag_hit_in) begin
            next_state = ST_IDLE; // Nothing cached to drop.
          end else if (act == `CPHU_ACT_FILL && tag_hit_in) begin
            next_state = ST_IDLE; // Block already present.
          end else begin
            next_state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (cache_ready_in) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register and latched operands.
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state     <= ST_IDLE;
      act       <= `CPHU_ACT_NONE;
      for_store <= 1'b0;
      place     <= `CPHU_PLACE_NORMAL;
      paddr     <= 32'h0000_0000;
      mat       <= 3'h0;
    end else begin
      state <= next_state;
      if (accept) begin
        act       <= dec_act;
        for_store <= dec_store;
        place     <= dec_place;
      end
      if (state == ST_XWT && xlat_done_in) begin
        paddr <= xlat_paddr_in;
        mat   <= xlat_mat_in;
      end
    end
  end

  // Output registers toward pipeline, translation and cache.
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      retire_out          <= 1'b0;
      error_out           <= 1'b0;
      xlat_req_out        <= 1'b0;
      xlat_vaddr_out      <= 32'h0000_0000;
      tag_req_out         <= 1'b0;
      tag_addr_out        <= 32'h0000_0000;
      cache_cmd_valid_out <= 1'b0;
      cache_cmd_out       <= `CPHU_ACT_NONE;
      cache_addr_out      <= 32'h0000_0000;
      cache_mat_out       <= 3'h0;
      cache_for_store_out <= 1'b0;
      cache_place_out     <= `CPHU_PLACE_NORMAL;
    end else begin
      // Retire the cycle after acceptance; the rest runs behind it.
      retire_out <= accept;
      // Side-effect errors are deliberately never reported here.
      error_out  <= cache_err_in & `CPHU_REPORT_ERR;
      xlat_req_out <= (next_state == ST_XREQ);
      if (accept) begin
        xlat_vaddr_out <= ea;
      end
      tag_req_out <= (next_state == ST_TREQ);
      if (state == ST_XWT && xlat_done_in) begin
        tag_addr_out <= xlat_paddr_in;
      end
      // Command holds until the cache takes it.
      if (state == ST_TWT && next_state == ST_CMD) begin
        cache_cmd_valid_out <= 1'b1;
        cache_cmd_out       <= act;
        cache_addr_out      <= paddr;
        cache_mat_out       <= mat;
        cache_for_store_out <= for_store;
        cache_place_out     <= place;
      end else if (state == ST_CMD && cache_ready_in) begin
        cache_cmd_valid_out <= 1'b0;
      end
    end
  end
  // The cache runs write-back of dirty victims before zeroing or invalidating;
  // this unit never moves data itself, so invisible writebacks stay there.
endmodule // cphu_unit

//--- testbench/cphu_far_model.sv
// Far-side model: address translation, tag lookup and cache acceptance.
module cphu_far_model (
  input  wire logic        ref_clk_in,      // Core clock.
  input  wire logic        reset_n_in,      // Reset, active low.
  input  wire logic        xlat_req_in,     // Translation request.
  input  wire logic [31:0] xlat_vaddr_in,   // Address to translate.
  input  wire logic        tag_req_in,      // Lookup request.
  input  wire logic [8:0]  cfg_in,          // Answer settings from the bench.
  output wire logic        xlat_done_out,   // Translation answer.
  output wire logic [37:0] xlat_info_out,   // Hit, fault, cached, type, address.
  output wire logic        tag_done_out,    // Lookup answer.
  output wire logic [2:0]  tag_info_out,    // Hit, dirty, locked.
  output wire logic        cache_ready_out  // Cache takes a command.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  xlat_wait;  // Cycles left to the translation answer.
  logic [1:0]  tag_wait;   // Cycles left to the lookup answer.
  logic [31:0] phys;       // Physical address to hand back.
  logic        tick;       // Toggles so a slow cache refuses every other cycle.
  wire  [37:0] xv = {cfg_in[0], cfg_in[1], cfg_in[2], cfg_in[5:3], phys};
  wire  [2:0]  tv = {cfg_in[6], 1'b1, cfg_in[7]};
  // Outside the answer cycle the lines show inverted values, so stale use shows up.
  assign xlat_done_out   = (xlat_wait == 2'h1);
  assign xlat_info_out   = xlat_done_out ? xv : ~xv;
  assign tag_done_out    = (tag_wait == 2'h1);
  assign tag_info_out    = tag_done_out ? tv : ~tv;
  assign cache_ready_out = !cfg_in[8] || tick;
  // Slow mode answers after three cycles instead of one.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xlat_wait <= 2'h0;
      tag_wait  <= 2'h0;
      phys      <= 32'h0;
      tick      <= 1'b0;
    end else begin
      tick <= ~tick;
      if (xlat_req_in) begin
        phys <= xlat_vaddr_in + 32'h1000_0000;
      end
      xlat_wait <= xlat_req_in ? {cfg_in[8], 1'b1} : xlat_wait - {1'b0, |xlat_wait};
      tag_wait  <= tag_req_in ? {cfg_in[8], 1'b1} : tag_wait - {1'b0, |tag_wait};
    end
  end
endmodule // cphu_far_model

//--- testbench/cphu_unit_asserts.sv
// Concurrent checks on the prefetch unit's ports.
`include "cphu_consts.vh"
module cphu_unit_asserts (
  input wire logic ref_clk_in, reset_n_in, issue_valid_in, issue_ready_out, // Issue side.
  input wire logic [31:0] issue_instr_in, issue_base_in, xlat_vaddr_out,   // Words.
  input wire logic retire_out, error_out, xlat_req_out, xlat_done_in,      // Pulses.
  input wire logic xlat_hit_in, xlat_fault_in, xlat_cached_in,             // Answer.
  input wire logic [2:0] xlat_mat_in, cache_cmd_out, cache_mat_out,        // Codes.
  input wire logic [31:0] xlat_paddr_in, tag_addr_out, cache_addr_out,     // Addresses.
  input wire logic tag_req_out, tag_done_in, tag_hit_in, tag_locked_in,    // Lookup.
  input wire logic cache_ready_in, cache_cmd_valid_out, cache_for_store_out, // Cache.
  input wire logic [1:0] cache_place_out                                   // Placement.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire take = issue_valid_in && issue_ready_out && issue_instr_in[31:26] == `CPHU_OPC_FETCH;
  wire [31:0] ea = issue_base_in + {{16{issue_instr_in[15]}}, issue_instr_in[15:0]};
  logic [4:0]  taken_hint;  // Hint of the prefetch in flight.
  logic [2:0]  seen_mat;    // Access type from translation.
  logic [31:0] seen_paddr;  // Address from translation.
  // Expected action per hint; reserved and free codes do nothing.
  function automatic logic [2:0] exp_act(input logic [4:0] h);
    case (h)
      5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07: exp_act = `CPHU_ACT_FILL;
      5'h19: exp_act = `CPHU_ACT_WB_INV;
      5'h1e: exp_act = `CPHU_ACT_ZERO;
      default: exp_act = `CPHU_ACT_NONE;
    endcase
  endfunction
  // Remember what each command must carry.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      taken_hint <= 5'h0;
      seen_mat   <= 3'h0;
      seen_paddr <= 32'h0;
    end else begin
      if (take) begin
        taken_hint <= issue_instr_in[20:16];
      end
      if (xlat_done_in) begin
        seen_mat   <= xlat_mat_in;
        seen_paddr <= xlat_paddr_in;
      end
    end
  end
  a_retire_next: assert property (take |=> retire_out &&
    xlat_req_out == (exp_act($past(issue_instr_in[20:16])) != 3'h0) &&
    xlat_vaddr_out == $past(ea)) else $error("retire or address wrong");
  a_other_ignored: assert property (issue_valid_in && issue_ready_out &&
    issue_instr_in[31:26] != `CPHU_OPC_FETCH |=> !retire_out && !xlat_req_out)
    else $error("other opcode taken");
  a_no_error: assert property (!error_out) else $error("error reported");
  a_bad_xlat_drop: assert property (xlat_done_in && (!xlat_hit_in || xlat_fault_in ||
    !xlat_cached_in) |=> (!tag_req_out && !cache_cmd_valid_out) [*3]) else $error("fault not dropped");
  a_tag_follows: assert property (xlat_done_in && xlat_hit_in && !xlat_fault_in &&
    xlat_cached_in |=> tag_req_out && tag_addr_out == $past(xlat_paddr_in)) else $error("no lookup");
  a_locked_kept: assert property (tag_done_in && tag_locked_in |=> !cache_cmd_valid_out [*2])
    else $error("locked line touched");
  a_zero_hit: assert property (tag_done_in && tag_hit_in && taken_hint == `CPHU_HINT_ZERO
    |=> !cache_cmd_valid_out [*2]) else $error("zero line on hit");
  a_cmd_class: assert property ($rose(cache_cmd_valid_out) |-> cache_cmd_out != 3'h0 &&
    cache_cmd_out == exp_act(taken_hint)) else $error("wrong action");
  a_fill_place: assert property ($rose(cache_cmd_valid_out) && cache_cmd_out == 3'h1 |->
    {cache_for_store_out, cache_place_out} == {taken_hint[0], taken_hint[2] ?
    {taken_hint[1], ~taken_hint[1]} : 2'h0}) else $error("wrong placement");
  a_cmd_path: assert property ($rose(cache_cmd_valid_out) |-> cache_mat_out == seen_mat &&
    cache_addr_out == seen_paddr) else $error("wrong type or address");
  a_cmd_hold: assert property (cache_cmd_valid_out && !cache_ready_in |=> cache_cmd_valid_out &&
    $stable(cache_addr_out)) else $error("command dropped");
endmodule // cphu_unit_asserts
bind cphu_unit cphu_unit_asserts u_cphu_unit_asserts (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .issue_valid_in(issue_valid_in), .issue_ready_out(issue_ready_out),
  .issue_instr_in(issue_instr_in), .issue_base_in(issue_base_in),
  .xlat_vaddr_out(xlat_vaddr_out), .retire_out(retire_out), .error_out(error_out),
  .xlat_req_out(xlat_req_out), .xlat_done_in(xlat_done_in), .xlat_hit_in(xlat_hit_in),
  .xlat_fault_in(xlat_fault_in), .xlat_cached_in(xlat_cached_in), .xlat_mat_in(xlat_mat_in),
  .cache_cmd_out(cache_cmd_out), .cache_mat_out(cache_mat_out), .xlat_paddr_in(xlat_paddr_in),
  .tag_addr_out(tag_addr_out), .cache_addr_out(cache_addr_out), .tag_req_out(tag_req_out),
  .tag_done_in(tag_done_in), .tag_hit_in(tag_hit_in), .tag_locked_in(tag_locked_in),
  .cache_ready_in(cache_ready_in), .cache_cmd_valid_out(cache_cmd_valid_out),
  .cache_for_store_out(cache_for_store_out), .cache_place_out(cache_place_out));

//--- testbench/tb_cache_prefetch_hint_unit.sv
// Self-checking bench for the prefetch hint unit.
`include "cphu_consts.vh"
module tb_cache_prefetch_hint_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, iv = 1'b0, err = 1'b0;  // Clock, reset, issue, error.
  logic [31:0] ii = 32'h0, ib = 32'h0010_0000;          // Instruction and base.
  logic [8:0]  cfg = 9'h0;                              // Far-side answer settings.
  wire rdy, ret, er, xrq, xdn, trq, tdn, cv, crdy, fs;
  wire [4:0] bsel;
  wire [31:0] xva, tad, cad;
  wire [37:0] xi;
  wire [2:0] ti, cmd, mat;
  wire [1:0] pl;
  int n_fail = 0, checks = 0;
  logic seen, s_fs;           // Command taken, and its write intent.
  logic [2:0] s_cmd, s_mat;   // Taken action and access type.
  logic [1:0] s_pl;           // Taken placement.
  logic [31:0] s_addr;        // Taken address.
  cphu_unit u_cphu_unit (.ref_clk_in(clk), .reset_n_in(rst_n), .issue_valid_in(iv),
    .issue_instr_in(ii), .issue_base_in(ib), .issue_base_sel_out(bsel), .issue_ready_out(rdy),
    .retire_out(ret), .error_out(er), .xlat_req_out(xrq), .xlat_vaddr_out(xva),
    .xlat_done_in(xdn), .xlat_hit_in(xi[37]), .xlat_fault_in(xi[36]), .xlat_cached_in(xi[35]),
    .xlat_mat_in(xi[34:32]), .xlat_paddr_in(xi[31:0]), .tag_req_out(trq), .tag_addr_out(tad),
    .tag_done_in(tdn), .tag_hit_in(ti[2]), .tag_dirty_in(ti[1]), .tag_locked_in(ti[0]),
    .cache_ready_in(crdy), .cache_cmd_valid_out(cv), .cache_cmd_out(cmd), .cache_addr_out(cad),
    .cache_mat_out(mat), .cache_for_store_out(fs), .cache_place_out(pl), .cache_err_in(err));
  cphu_far_model u_cphu_far_model (.ref_clk_in(clk), .reset_n_in(rst_n), .xlat_req_in(xrq),
    .xlat_vaddr_in(xva), .tag_req_in(trq), .cfg_in(cfg), .xlat_done_out(xdn),
    .xlat_info_out(xi), .tag_done_out(tdn), .tag_info_out(ti), .cache_ready_out(crdy));
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Issue one prefetch, then follow it until the unit is idle again.
  task automatic do_pf(input logic [31:0] ins, input logic [8:0] c);
    int k;
    @(posedge clk);
    iv <= 1'b1;
    ii <= ins;
    cfg <= c;
    err <= c[8];  // Side-effect errors are raised during slow runs.
    @(posedge clk);
    iv <= 1'b0;
    seen = 1'b0;
    k = 0;
    #1 chk(ret, 32'h1);
    chk(xva, ib + {{16{ins[15]}}, ins[15:0]});
    chk(bsel, ins[25:21]);
    do begin
      @(posedge clk);
      if (cv === 1'b1 && crdy === 1'b1) begin
        {seen, s_cmd, s_fs, s_pl, s_mat, s_addr} = {1'b1, cmd, fs, pl, mat, cad};
      end
      k++;
    end while (rdy !== 1'b1 && k < 40);
    chk(rdy, 32'h1);
    chk(er, 32'h0);
  endtask
  // Every hint code on a cache miss, with slow and prompt far sides.
  task automatic t_hints();
    logic [4:0] h;
    logic fl;
    logic [15:0] d;
    for (int i = 0; i < 32; i++) begin
      h = i[4:0];
      fl = h < 5'h2 || (h >= 5'h4 && h <= 5'h7);
      d = i[0] ? 16'hfff0 : 16'h0040;
      do_pf({`CPHU_OPC_FETCH, 5'h03, h, d}, {i[0], 2'b00, h[2:0], 3'h5});
      chk(seen, fl || h == 5'h1e);
      if (seen) begin
        chk(s_cmd, fl ? `CPHU_ACT_FILL : `CPHU_ACT_ZERO);
        chk(s_addr, ib + {{16{d[15]}}, d} + 32'h1000_0000);
        chk(s_mat, h[2:0]);
      end
      if (fl) chk({s_fs, s_pl}, {h[0], h[2] ? {h[1], ~h[1]} : 2'h0});
    end
  endtask
  // Translation miss, fault, uncached and locked lines move nothing.
  task automatic t_drops();
    logic [8:0] tbl [5] = '{9'h004, 9'h007, 9'h001, 9'h085, 9'h185};
    for (int i = 0; i < 5; i++) begin
      do_pf({`CPHU_OPC_FETCH, 5'h02, i == 4 ? `CPHU_HINT_ZERO : 5'h00, 16'h0010}, tbl[i]);
      chk(seen, 32'h0);
    end
  endtask
  // Hits: flush-and-drop proceeds, zero allocation does nothing.
  task automatic t_hits();
    do_pf({`CPHU_OPC_FETCH, 5'h01, `CPHU_HINT_WB_INV, 16'h0100}, 9'h145);
    chk({seen, s_cmd}, {1'b1, `CPHU_ACT_WB_INV});
    do_pf({`CPHU_OPC_FETCH, 5'h01, `CPHU_HINT_ZERO, 16'h0100}, 9'h045);
    chk(seen, 32'h0);
  endtask
  // Another opcode is not taken.
  task automatic t_ignore();
    @(posedge clk);
    iv <= 1'b1;
    ii <= {6'h00, 5'h03, 5'h00, 16'h0040};
    @(posedge clk);
    iv <= 1'b0;
    #1 chk({ret, xrq, rdy}, 32'h1);
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_ignore();
    t_hints();
    t_drops();
    t_hits();
    finish_test();
  end
endmodule // tb_cache_prefetch_hint_unit
